// >>> hdl/cfp_pkg.sv
// package: register map, field layout and carriers of the can filter and fifo pointer block
package cfp_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned CFP_NUM_FIFO = 32;
  localparam int unsigned CFP_IDX_W = 5;
  localparam int unsigned CFP_ADR_W = 12;
  localparam int unsigned CFP_ALIGN_BITS = 2;
  localparam int unsigned CFP_MSG_SHIFT = 4;
  localparam int unsigned CFP_FIFO_SHIFT = 9;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] CFP_OFS_FILTER = 12'h000;
  localparam logic [11:0] CFP_OFS_DIR = 12'h004;
  localparam logic [11:0] CFP_OFS_BASE = 12'h008;
  localparam logic [11:0] CFP_OFS_CTRL = 12'h00C;
  localparam logic [11:0] CFP_OFS_FULL = 12'h010;
  localparam logic [11:0] CFP_OFS_EMPTY = 12'h014;
  localparam logic [3:0] CFP_PAGE_UPTR = 4'h1;
  localparam logic [3:0] CFP_PAGE_MPOS = 4'h2;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned CFP_F24_BYTE = 0;
  localparam int unsigned CFP_F25_BYTE = 1;
  localparam int unsigned CFP_CTRL_CFG_POS = 0;
  localparam logic [31:0] CFP_DIR_RESET = 32'h0000_0000;
  localparam logic [31:0] CFP_BASE_RESET = 32'h0000_0000;
  localparam logic CFP_CFG_RESET = 1'b0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic filter_on;
    logic [1:0] mask_choice;
    logic [4:0] fifo_target;
  } cfp_filter_t;

  localparam cfp_filter_t CFP_FILTER_RESET = '0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [CFP_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cfp_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } cfp_wb_rsp_t;

  typedef struct packed {
    logic valid;
    logic from_filter25;
    logic [1:0] mask_choice;
    logic [4:0] fifo_target;
  } cfp_accept_t;

  typedef struct packed {
    logic valid;
    logic [4:0] fifo;
  } cfp_fifo_evt_t;

  typedef struct packed {
    logic [CFP_IDX_W-1:0] head;
    logic [CFP_IDX_W-1:0] tail;
    logic [CFP_IDX_W:0] count;
  } cfp_ptr_t;

  localparam cfp_ptr_t CFP_PTR_RESET = '0;
  localparam logic [CFP_IDX_W:0] CFP_PTR_FULL = 6'h20;

endpackage : cfp_pkg

// >>> hdl/cfp_fifo_ptr.sv
// module: head, tail and fill count of one message fifo
`timescale 1ns/10ps
module cfp_fifo_ptr (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pointer control
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  // pointer state
  output cfp_pkg::cfp_ptr_t ptr
);
  import cfp_pkg::*;

  cfp_ptr_t state;
  cfp_ptr_t next_state;
  logic do_push;
  logic do_pop;

  // ****************************************************************
  // pointer update
  // ****************************************************************
  // a push into a full fifo or a pop from an empty one is dropped
  assign do_push = push && (state.count != CFP_PTR_FULL);
  assign do_pop = pop && (state.count != '0);

  always_comb begin
    next_state = state;
    if (clear) begin
      next_state = CFP_PTR_RESET;
    end else begin
      if (do_push) begin
        next_state.head = state.head + 5'h1;
      end
      if (do_pop) begin
        next_state.tail = state.tail + 5'h1;
      end
      if (do_push && !do_pop) begin
        next_state.count = state.count + 6'h1;
      end else if (do_pop && !do_push) begin
        next_state.count = state.count - 6'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= CFP_PTR_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign ptr = state;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_head_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (push && !clear && state.count != CFP_PTR_FULL) |=> state.head == $past(state.head) + 5'h1)
    else $error("fifo head did not advance on a push");

  chk_tail_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pop && !clear && state.count != '0) |=> state.tail == $past(state.tail) + 5'h1)
    else $error("fifo tail did not advance on a pop");

endmodule : cfp_fifo_ptr

// >>> hdl/cfp_top.sv
// module: filter 24/25 control, fifo direction and per-fifo pointer registers on wishbone
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module cfp_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone slave
  input cfp_pkg::cfp_wb_req_t wb_req,
  output cfp_pkg::cfp_wb_rsp_t wb_rsp,
  // filter match logic
  input wire logic [1:0] filter_match,
  output cfp_pkg::cfp_filter_t [1:0] filter_cfg,
  output cfp_pkg::cfp_accept_t accept,
  // message movement from the protocol engine and fifo control
  input cfp_pkg::cfp_fifo_evt_t fifo_push,
  input cfp_pkg::cfp_fifo_evt_t fifo_pop,
  // mode
  output logic config_mode
);
  import cfp_pkg::*;

  typedef struct packed {
    cfp_wb_rsp_t rsp;
    cfp_filter_t [1:0] filt;
    logic [31:0] dir;
    logic [31:0] base;
    logic cfg_mode;
    cfp_accept_t accept;
  } cfp_top_state_t;

  cfp_top_state_t state;
  cfp_top_state_t next_state;
  cfp_ptr_t ptrs [CFP_NUM_FIFO];
  logic [31:0] full_map;
  logic [31:0] empty_map;
  logic take;
  logic take_rd;
  logic take_wr;
  logic is_uptr;
  logic is_mpos;
  logic is_reg;
  logic [4:0] fidx;
  logic [31:0] tx_addr;
  logic [31:0] rx_addr;
  logic [31:0] rd_word;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] cfp_merge(input logic [31:0] old_word,
                                            input logic [31:0] new_word,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res;
  endfunction : cfp_merge

  function automatic logic [4:0] cfp_fifo_index(input logic [CFP_ADR_W-1:0] adr);
    return adr[6:2];
  endfunction : cfp_fifo_index

  function automatic logic cfp_in_page(input logic [CFP_ADR_W-1:0] adr,
                                       input logic [3:0] page);
    return (adr[11:8] == page) && !adr[7];
  endfunction : cfp_in_page

  // user address of message slot idx of fifo n, word aligned
  function automatic logic [31:0] cfp_user_addr(input logic [31:0] base,
                                                input logic [4:0] n,
                                                input logic [4:0] idx);
    logic [31:0] a;
    a = base + {18'h0, n, idx, 4'h0};
    a[CFP_ALIGN_BITS-1:0] = '0;
    return a;
  endfunction : cfp_user_addr

  // ****************************************************************
  // fifo pointers
  // ****************************************************************
  // pointers are held cleared in configuration mode, so reads there are not meaningful
  for (genvar i = 0; i < CFP_NUM_FIFO; i++) begin : g_fifo
    cfp_fifo_ptr u_ptr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clear(state.cfg_mode),
      .push(fifo_push.valid && (fifo_push.fifo == 5'(i))),
      .pop(fifo_pop.valid && (fifo_pop.fifo == 5'(i))),
      .ptr(ptrs[i])
    );
    assign full_map[i] = (ptrs[i].count == CFP_PTR_FULL);
    assign empty_map[i] = (ptrs[i].count == '0);
  end

  // ****************************************************************
  // bus decode and read mux
  // ****************************************************************
  assign take = wb_req.cyc && wb_req.stb && !state.rsp.ack;
  assign take_rd = take && !wb_req.we;
  assign take_wr = take && wb_req.we;
  assign is_uptr = cfp_in_page(wb_req.adr, CFP_PAGE_UPTR);
  assign is_mpos = cfp_in_page(wb_req.adr, CFP_PAGE_MPOS);
  assign is_reg = wb_req.adr inside {CFP_OFS_FILTER, CFP_OFS_DIR, CFP_OFS_BASE, CFP_OFS_CTRL,
                                     CFP_OFS_FULL, CFP_OFS_EMPTY};
  assign fidx = cfp_fifo_index(wb_req.adr);
  assign tx_addr = cfp_user_addr(state.base, fidx, ptrs[fidx].head);
  assign rx_addr = cfp_user_addr(state.base, fidx, ptrs[fidx].tail);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_uptr) begin
      rd_word = state.dir[fidx] ? tx_addr : rx_addr;
    end else if (is_mpos) begin
      // transmit: next message to send; receive: next slot to fill
      rd_word[CFP_IDX_W-1:0] = state.dir[fidx] ? ptrs[fidx].tail : ptrs[fidx].head;
    end else begin
      unique case (wb_req.adr)
        CFP_OFS_FILTER: rd_word[15:0] = state.filt;
        CFP_OFS_DIR: rd_word = state.dir;
        CFP_OFS_BASE: rd_word = state.base;
        CFP_OFS_CTRL: rd_word[CFP_CTRL_CFG_POS] = state.cfg_mode;
        CFP_OFS_FULL: rd_word = full_map;
        CFP_OFS_EMPTY: rd_word = empty_map;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [31:0] ctrl_word;
    cfp_filter_t wr_filt;
    ctrl_word = cfp_merge({31'h0, state.cfg_mode}, wb_req.dat, wb_req.sel);
    wr_filt = CFP_FILTER_RESET;
    next_state = state;
    next_state.rsp.ack = take;
    next_state.rsp.dat = take_rd ? rd_word : 32'h0000_0000;
    if (take_wr) begin
      unique case (wb_req.adr)
        CFP_OFS_FILTER: begin
          for (int f = 0; f < 2; f++) begin
            if (wb_req.sel[f]) begin
              wr_filt = wb_req.dat[f*8 +: 8];
              next_state.filt[f].filter_on = wr_filt.filter_on;
              // fields are locked while the filter is on
              if (!state.filt[f].filter_on) begin
                next_state.filt[f].mask_choice = wr_filt.mask_choice;
                next_state.filt[f].fifo_target = wr_filt.fifo_target;
              end
            end
          end
        end
        CFP_OFS_DIR: next_state.dir = cfp_merge(state.dir, wb_req.dat, wb_req.sel);
        CFP_OFS_BASE: next_state.base = cfp_merge(state.base, wb_req.dat, wb_req.sel);
        CFP_OFS_CTRL: next_state.cfg_mode = ctrl_word[CFP_CTRL_CFG_POS];
        default: next_state.cfg_mode = state.cfg_mode;
      endcase
    end
    // acceptance: filter 24 wins over filter 25 on a double match
    next_state.accept = '0;
    if (filter_match[CFP_F24_BYTE] && state.filt[CFP_F24_BYTE].filter_on) begin
      next_state.accept.valid = 1'b1;
      next_state.accept.mask_choice = state.filt[CFP_F24_BYTE].mask_choice;
      next_state.accept.fifo_target = state.filt[CFP_F24_BYTE].fifo_target;
    end else if (filter_match[CFP_F25_BYTE] && state.filt[CFP_F25_BYTE].filter_on) begin
      next_state.accept.valid = 1'b1;
      next_state.accept.from_filter25 = 1'b1;
      next_state.accept.mask_choice = state.filt[CFP_F25_BYTE].mask_choice;
      next_state.accept.fifo_target = state.filt[CFP_F25_BYTE].fifo_target;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state.rsp <= '0;
      state.filt <= {CFP_FILTER_RESET, CFP_FILTER_RESET};
      state.dir <= CFP_DIR_RESET;
      state.base <= CFP_BASE_RESET;
      state.cfg_mode <= CFP_CFG_RESET;
      state.accept <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_rsp = state.rsp;
  assign filter_cfg = state.filt;
  assign accept = state.accept;
  assign config_mode = state.cfg_mode;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_filter25_off: assert property (
    (filter_match == 2'b10 && !state.filt[1].filter_on) |=> !state.accept.valid)
    else $error("disabled filter 25 produced an acceptance");

  chk_filter25_mask: assert property (
    (filter_match == 2'b10 && state.filt[1].filter_on)
      |=> state.accept.valid && state.accept.from_filter25
          && state.accept.mask_choice == $past(state.filt[1].mask_choice))
    else $error("filter 25 acceptance carries the wrong mask");

  chk_filter25_fifo: assert property (
    (filter_match[1] && !filter_match[0] && state.filt[1].filter_on)
      |=> state.accept.fifo_target == $past(state.filt[1].fifo_target))
    else $error("filter 25 acceptance carries the wrong fifo");

  chk_filter24_route: assert property (
    (filter_match[0] && state.filt[0].filter_on)
      |=> state.accept.valid && !state.accept.from_filter25
          && state.accept.fifo_target == $past(state.filt[0].fifo_target)
          && state.accept.mask_choice == $past(state.filt[0].mask_choice))
    else $error("filter 24 acceptance wrong");

  chk_filter_lock: assert property (
    (state.filt[0].filter_on && state.filt[1].filter_on)
      |=> $stable(state.filt[0].fifo_target) && $stable(state.filt[1].mask_choice)
          && $stable(state.filt[1].fifo_target) && $stable(state.filt[0].mask_choice))
    else $error("locked filter field changed");

  chk_uptr_head: assert property (
    (take_rd && is_uptr && state.dir[fidx]) |=> wb_rsp.ack && wb_rsp.dat == $past(tx_addr))
    else $error("transmit user pointer is not the head address");

  chk_uptr_tail: assert property (
    (take_rd && is_uptr && !state.dir[fidx]) |=> wb_rsp.ack && wb_rsp.dat == $past(rx_addr))
    else $error("receive user pointer is not the tail address");

  chk_uptr_align: assert property (
    (take_rd && is_uptr) |=> wb_rsp.dat[1:0] == 2'b00)
    else $error("user pointer low bits not zero");

  chk_index_width: assert property (
    (take_rd && is_mpos) |=> wb_rsp.ack && wb_rsp.dat[31:5] == '0 ##1 !wb_rsp.ack)
    else $error("message index upper bits not zero");

  chk_index_tx: assert property (
    (take_rd && is_mpos && state.dir[fidx])
      |=> wb_rsp.dat[4:0] == $past(ptrs[fidx].tail))
    else $error("transmit index is not the next message to send");

  chk_index_rx: assert property (
    (take_rd && is_mpos && !state.dir[fidx])
      |=> wb_rsp.dat[4:0] == $past(ptrs[fidx].head))
    else $error("receive index is not the next slot to fill");

  chk_ack_pulse: assert property (
    take |=> wb_rsp.ack ##1 !wb_rsp.ack)
    else $error("bus acknowledge is not a single-cycle pulse");

  chk_ack_cause: assert property (
    !take |=> !wb_rsp.ack)
    else $error("bus acknowledge without a taken request");

  chk_write_dat: assert property (
    take_wr |=> wb_rsp.dat == 32'h0000_0000)
    else $error("write answered with nonzero data");

  chk_read_no_side: assert property (
    take_rd |=> $stable({state.filt, state.dir, state.base, state.cfg_mode}))
    else $error("register read changed a register");

  chk_unmapped_read: assert property (
    (take_rd && !is_reg && !is_uptr && !is_mpos) |=> wb_rsp.dat == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  chk_unmapped_write: assert property (
    (take_wr && !is_reg) |=> $stable({state.filt, state.dir, state.base, state.cfg_mode}))
    else $error("write to a read-only or unmapped address changed a register");

  chk_dir_write: assert property (
    (take_wr && wb_req.adr == CFP_OFS_DIR && wb_req.sel == 4'hF)
      |=> state.dir == $past(wb_req.dat))
    else $error("direction write did not land");

  chk_base_write: assert property (
    (take_wr && wb_req.adr == CFP_OFS_BASE && wb_req.sel == 4'hF)
      |=> state.base == $past(wb_req.dat))
    else $error("base write did not land");

  chk_cfg_write: assert property (
    (take_wr && wb_req.adr == CFP_OFS_CTRL && wb_req.sel[0])
      |=> config_mode == $past(wb_req.dat[CFP_CTRL_CFG_POS]))
    else $error("configuration mode write did not land");

  chk_filter_read: assert property (
    (take_rd && wb_req.adr == CFP_OFS_FILTER) |=> wb_rsp.dat == {16'h0000, $past(state.filt)})
    else $error("filter control read wrong");

  chk_ctrl_read: assert property (
    (take_rd && wb_req.adr == CFP_OFS_CTRL) |=> wb_rsp.dat == {31'h0, $past(state.cfg_mode)})
    else $error("control read wrong");

  chk_full_read: assert property (
    (take_rd && wb_req.adr == CFP_OFS_FULL) |=> wb_rsp.dat == $past(full_map))
    else $error("full map read wrong");

  chk_empty_read: assert property (
    (take_rd && wb_req.adr == CFP_OFS_EMPTY) |=> wb_rsp.dat == $past(empty_map))
    else $error("empty map read wrong");

  chk_enable_24: assert property (
    (take_wr && wb_req.adr == CFP_OFS_FILTER && wb_req.sel[0])
      |=> state.filt[0].filter_on == $past(wb_req.dat[7]))
    else $error("filter 24 enable write did not land");

  chk_enable_25: assert property (
    (take_wr && wb_req.adr == CFP_OFS_FILTER && wb_req.sel[1])
      |=> state.filt[1].filter_on == $past(wb_req.dat[15]))
    else $error("filter 25 enable write did not land");

  chk_fields_24: assert property (
    (take_wr && wb_req.adr == CFP_OFS_FILTER && wb_req.sel[0] && !state.filt[0].filter_on)
      |=> {state.filt[0].mask_choice, state.filt[0].fifo_target} == $past(wb_req.dat[6:0]))
    else $error("filter 24 fields not loaded while disabled");

  chk_fields_25: assert property (
    (take_wr && wb_req.adr == CFP_OFS_FILTER && wb_req.sel[1] && !state.filt[1].filter_on)
      |=> {state.filt[1].mask_choice, state.filt[1].fifo_target} == $past(wb_req.dat[14:8]))
    else $error("filter 25 fields not loaded while disabled");

  chk_lock_24: assert property (
    state.filt[0].filter_on
      |=> $stable(state.filt[0].mask_choice) && $stable(state.filt[0].fifo_target))
    else $error("filter 24 fields changed while enabled");

  chk_lock_25: assert property (
    state.filt[1].filter_on
      |=> $stable(state.filt[1].mask_choice) && $stable(state.filt[1].fifo_target))
    else $error("filter 25 fields changed while enabled");

  chk_accept_idle: assert property (
    (filter_match == 2'b00) |=> !accept.valid)
    else $error("acceptance without a filter match");

  chk_cfg_clear: assert property (
    state.cfg_mode |=> empty_map == 32'hFFFF_FFFF)
    else $error("fifo pointers not held clear in configuration mode");

endmodule : cfp_top

// >>> test/cfp_engine_model.sv
// partner: protocol engine side that drives filter matches and fifo message events
`timescale 1ns/10ps
module cfp_engine_model (
  // clock
  input wire logic core_clk,
  // engine outputs
  output logic [1:0] filter_match,
  output cfp_pkg::cfp_fifo_evt_t fifo_push,
  output cfp_pkg::cfp_fifo_evt_t fifo_pop
);
  import cfp_pkg::*;
  initial begin
    filter_match = 2'b00;
    fifo_push = '0;
    fifo_pop = '0;
  end
  // ****************************************************************
  // one message moved, then the fifo number is inverted so a stale one never looks live
  // ****************************************************************
  task automatic move(input logic psh, input logic pp, input logic [4:0] n);
    @(posedge core_clk);
    fifo_push <= '{valid: psh, fifo: n};
    fifo_pop <= '{valid: pp, fifo: n};
    @(posedge core_clk);
    fifo_push <= '{valid: 1'b0, fifo: ~n};
    fifo_pop <= '{valid: 1'b0, fifo: ~n};
  endtask : move
  task automatic match(input logic [1:0] m);
    @(posedge core_clk);
    filter_match <= m;
    @(posedge core_clk);
    filter_match <= 2'b00;
  endtask : match
endmodule : cfp_engine_model

// >>> test/cfp_top_tb_top.sv
// testbench: filter, register and fifo pointer checks against a behavioural model
`timescale 1ns/10ps
module cfp_top_tb_top;
  import cfp_pkg::*;
  logic core_clk;
  logic rst_n;
  cfp_wb_req_t wb_req;
  cfp_wb_rsp_t wb_rsp;
  logic [1:0] filter_match;
  cfp_filter_t [1:0] filter_cfg;
  cfp_accept_t accept;
  cfp_fifo_evt_t fifo_push;
  cfp_fifo_evt_t fifo_pop;
  logic config_mode;
  int num_errors = 0;
  int checked = 0;
  int seed = 18;
  int cycles = 0;
  logic [7:0] flt [2];
  int head [32];
  int tail [32];
  int cnt [32];
  logic [31:0] dir;
  logic [31:0] base;
  logic [31:0] q;
  logic [31:0] r;
  logic [15:0] t;

  cfp_top cfp_top_inst (.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .filter_match(filter_match), .filter_cfg(filter_cfg), .accept(accept),
    .fifo_push(fifo_push), .fifo_pop(fifo_pop), .config_mode(config_mode));
  cfp_engine_model cfp_engine_model_inst (.core_clk(core_clk), .filter_match(filter_match),
    .fifo_push(fifo_push), .fifo_pop(fifo_pop));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rq);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
    do begin
      @(posedge core_clk);
    end while (wb_rsp.ack !== 1'b1);
    rq = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, a, 32'h0000_0000, 4'hF, v);
    cmp(v, exp);
  endtask : rd
  // lock judged on the enable held before the write
  task automatic fw(input logic [15:0] d, input logic [3:0] s);
    for (int i = 0; i < 2; i++) begin
      if (s[i]) flt[i] = flt[i][7] ? {d[8*i+7], flt[i][6:0]} : d[8*i+:8];
    end
    wb(1'b1, CFP_OFS_FILTER, {16'h0000, d}, s, q);
  endtask : fw
  task automatic fchk();
    wb(1'b0, CFP_OFS_FILTER, 32'h0000_0000, 4'hF, q);
    cmp({16'h0000, q[15:0]}, {16'h0000, flt[1], flt[0]});
    cmp(filter_cfg, {flt[1], flt[0]});
  endtask : fchk
  // filter 24 wins when both match
  task automatic mt(input logic [1:0] m);
    logic [8:0] e;
    e = 9'h000;
    if (m[0] && flt[0][7]) e = {2'b10, flt[0][6:0]};
    else if (m[1] && flt[1][7]) e = {2'b11, flt[1][6:0]};
    cfp_engine_model_inst.match(m);
    #1;
    if (e[8]) cmp(accept, e);
    else cmp(accept.valid, 0);
  endtask : mt
  task automatic ev(input logic p, input int n);
    if (p && cnt[n] < 32) begin
      head[n] = (head[n] + 1) % 32;
      cnt[n]++;
    end
    if (!p && cnt[n] > 0) begin
      tail[n] = (tail[n] + 1) % 32;
      cnt[n]--;
    end
    cfp_engine_model_inst.move(p, !p, 5'(n));
  endtask : ev
  task automatic pchk(input int n);
    int idx;
    idx = dir[n] ? head[n] : tail[n];
    rd(12'h100 + 12'(4*n), (base + 32'(n*512 + idx*16)) & 32'hFFFF_FFFC);
    rd(12'h200 + 12'(4*n), 32'(dir[n] ? tail[n] : head[n]));
  endtask : pchk
  task automatic clear_model();
    foreach (head[i]) begin
      head[i] = 0;
      tail[i] = 0;
      cnt[i] = 0;
    end
  endtask : clear_model

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    wb_req = '0;
    dir = 32'h0000_0000;
    base = 32'h0000_0000;
    flt[0] = 8'h00;
    flt[1] = 8'h00;
    clear_model();
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CFP_OFS_FILTER, 32'h0000_0000);
    rd(CFP_OFS_DIR, CFP_DIR_RESET);
    pchk(5);
    wb(1'b1, 12'h180, 32'hFFFF_FFFF, 4'hF, q);
    rd(12'h180, 32'h0000_0000);
    rd(12'h2FC, 32'h0000_0000);
    $display("test reset and unmapped done");
    for (int k = 0; k < 4; k++) begin
      t = 16'($random(seed));
      t = {1'b1, 2'(3 - k), t[12:8], 1'b1, 2'(k), t[4:0]};
      if (k == 0) t = {t[15:13], 5'h1F, t[7:5], 5'h00};
      if (k == 3) t = {t[15:13], 5'h00, t[7:5], 5'h1F};
      fw(16'h0000, 4'hF);
      mt(2'b01);
      fw(t, 4'hF);
      fchk();
      mt(2'b01);
      mt(2'b10);
      mt(2'b11);
      fw(~t, 4'hF);
      fchk();
      mt(2'b10);
    end
    fw(16'h9F9F, 4'h2);
    fchk();
    mt(2'b10);
    $display("test filters done");
    base = $random(seed);
    dir = $random(seed);
    wb(1'b1, CFP_OFS_BASE, base, 4'hF, q);
    wb(1'b1, CFP_OFS_DIR, dir, 4'hF, q);
    rd(CFP_OFS_DIR, dir);
    rd(CFP_OFS_BASE, base);
    repeat (34) ev(1'b1, 2);
    pchk(2);
    rd(CFP_OFS_FULL, 32'h0000_0004);
    rd(CFP_OFS_EMPTY, 32'hFFFF_FFFB);
    repeat (36) ev(1'b0, 2);
    pchk(2);
    rd(CFP_OFS_FULL, 32'h0000_0000);
    rd(CFP_OFS_EMPTY, 32'hFFFF_FFFF);
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      ev(r[1] | r[0], r[4] ? 31 : int'(r[3:2]));
    end
    for (int i = 0; i < 5; i++) pchk(i == 4 ? 31 : i);
    $display("test fifo pointers done");
    wb(1'b1, CFP_OFS_CTRL, 32'h0000_0001, 4'hF, q);
    cmp(config_mode, 1);
    rd(CFP_OFS_CTRL, 32'h0000_0001);
    cfp_engine_model_inst.move(1'b1, 1'b0, 5'h01);
    wb(1'b1, CFP_OFS_CTRL, 32'h0000_0000, 4'hF, q);
    clear_model();
    pchk(1);
    pchk(31);
    $display("test configuration mode done");
    complete_run();
  end
endmodule : cfp_top_tb_top
